// [core/crtc_timing_cursor_consts.svh]
// Register indices, field positions and reset values of the timing and cursor block
`ifndef CRTC_TIMING_CURSOR_CONSTS_SVH
`define CRTC_TIMING_CURSOR_CONSTS_SVH

// ----------------------------------------------------------------
// Port select and register indices
// ----------------------------------------------------------------
`define PORT_INDEX        1'b0
`define PORT_DATA         1'b1
`define IDX_HBLANK_START  6'h02
`define IDX_HBLANK_END    6'h03
`define IDX_HRTR_START    6'h04
`define IDX_HRTR_END      6'h05
`define IDX_VTOTAL        6'h06
`define IDX_OVERFLOW      6'h07
`define IDX_PRESET        6'h08
`define IDX_MAXSCAN       6'h09
`define IDX_CUR_START     6'h0a
`define IDX_CUR_END       6'h0b
`define IDX_START_HIGH    6'h0c
`define IDX_START_LOW     6'h0d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SKEW_MSB          6
`define SKEW_LSB          5
`define LOW5_MSB          4
`define LOW6_MSB          5
`define HBLANK_END_B5     7
`define LOCK_VERT_BIT     0
`define LOCK_DISPEND_BIT  1
`define LOCK_ADDR_LSB     3
`define LOCK_ADDR_MSB     4
`define LOCK_HORIZ_BIT    5
`define OVF_VT8           0
`define OVF_DE8           1
`define OVF_VR8           2
`define OVF_VB8           3
`define OVF_LC8           4
`define OVF_VT9           5
`define OVF_DE9           6
`define OVF_VR9           7
`define MAXSCAN_VB9       5
`define MAXSCAN_LC9       6
`define MAXSCAN_DOUBLE    7
`define CURSOR_OFF_BIT    5
`define LEGACY_VT_MSB     6

// ----------------------------------------------------------------
// Masks, reset values and counts
// ----------------------------------------------------------------
`define REG_RESET         8'h00
`define ALL_BITS          8'hff
`define OVF_MASK_VLOCK    8'had
`define OVF_MASK_DELOCK   8'h42
`define MAXSCAN_MASK_VB9  8'h20
`define HBLANK_END_MASK   8'h7f
`define PRESET_MASK       8'h7f
`define CUR_START_MASK    8'h3f
`define CUR_END_MASK      8'h7f
`define LEGACY_HIGH_MASK  8'h3f
`define HTOTAL_ADJ        9'h004
`define SKEW_NONE         2'h0

`endif

// [core/crtc_timing_pkg.sv]
// Types shared by the timing and cursor block
package crtc_timing_pkg;

	// ----------------------------------------------------------------
	// Indexed I/O request and upper vertical field bits
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       write;
		logic       read;
		logic       portSel;
		logic [7:0] data;
	} io_req_t;

	typedef struct packed {
		logic [1:0] retraceStart;
		logic [1:0] dispEnd;
		logic [1:0] startBlank;
		logic [1:0] lineCompare;
	} vert_high_t;

endpackage : crtc_timing_pkg

// [core/crtc_timing_cursor_regs.sv]
// Horizontal timing, row scan, cursor and start address registers on the character clock
`include "crtc_timing_cursor_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module crtc_timing_cursor_regs (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire crtc_timing_pkg::io_req_t    ioReq,
	input  wire logic [7:0]                  extLockControlReg,
	input  wire logic                        timingWriteProtect,
	input  wire logic                        legacyMode,
	input  wire logic                        multiShiftMode,
	input  wire logic [7:0]                  horizTotal,
	input  wire logic [7:0]                  horizDisplayEnd,
	input  wire logic                        vertTotalBit10,
	input  wire logic                        vRetrace,
	input  wire logic                        cursorAddrHit,
	output logic [7:0]                       ioReadData,
	output logic                             hRetrace,
	output logic                             hBlank,
	output logic                             displayEnable,
	output logic                             cursorVideo,
	output logic [4:0]                       rowScan,
	output logic [1:0]                       bytePan,
	output logic [10:0]                      vertTotal,
	output crtc_timing_pkg::vert_high_t      vertHigh,
	output logic [17:0]                      startAddress
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] allow);
		mergeBits = (old & ~allow) | (val & allow);
	endfunction : mergeBits
	// Skew 0 passes the current level, otherwise a tap of the delay line
	function automatic logic pickDelayed(input logic now, input logic [2:0] line,
		input logic [1:0] sel);
		pickDelayed = (sel == `SKEW_NONE) ? now : line[sel - 2'h1];
	endfunction : pickDelayed
	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [5:0]  index;
	logic [7:0]  horizBlankStart;
	logic [7:0]  horizBlankEnd;
	logic [7:0]  horizRetraceStart;
	logic [7:0]  horizRetraceEnd;
	logic [7:0]  verticalTotalLow;
	logic [7:0]  verticalOverflowBits;
	logic [7:0]  rowScanPreset;
	logic [7:0]  maxScanLine;
	logic [7:0]  cursorStartLine;
	logic [7:0]  cursorEndLine;
	logic [7:0]  screenStartHigh;
	logic [7:0]  screenStartLow;
	// ----------------------------------------------------------------
	// Write decode and locks
	// ----------------------------------------------------------------
	wire         dataWrite  = ioReq.write && (ioReq.portSel == `PORT_DATA);
	wire         indexWrite = ioReq.write && (ioReq.portSel == `PORT_INDEX);
	wire [7:0]   wdata      = ioReq.data;
	wire         horizLock  = extLockControlReg[`LOCK_HORIZ_BIT] | timingWriteProtect;
	wire         vertLock   = extLockControlReg[`LOCK_VERT_BIT] | timingWriteProtect;
	// display-end bits lock only in this combination
	wire         deLock     = !extLockControlReg[`LOCK_DISPEND_BIT] && timingWriteProtect;
	// overflow allow mask; line compare bit always open
	wire [7:0]   ovfAllow   = `ALL_BITS & ~(vertLock ? `OVF_MASK_VLOCK : `REG_RESET)
		& ~(deLock ? `OVF_MASK_DELOCK : `REG_RESET);
	// start blank bit 9 locked by vertical lock bit only
	wire [7:0]   maxAllow   = extLockControlReg[`LOCK_VERT_BIT] ? ~`MAXSCAN_MASK_VB9 : `ALL_BITS;
	wire         wrHbStart  = dataWrite && (index == `IDX_HBLANK_START) && !horizLock;
	wire         wrHbEnd    = dataWrite && (index == `IDX_HBLANK_END) && !horizLock;
	wire         wrHrStart  = dataWrite && (index == `IDX_HRTR_START) && !horizLock;
	wire         wrHrEnd    = dataWrite && (index == `IDX_HRTR_END) && !horizLock;
	wire         wrVtotal   = dataWrite && (index == `IDX_VTOTAL) && !vertLock;
	wire         wrOvf      = dataWrite && (index == `IDX_OVERFLOW);
	wire         wrPreset   = dataWrite && (index == `IDX_PRESET);
	wire         wrMaxScan  = dataWrite && (index == `IDX_MAXSCAN);
	wire         wrCurStart = dataWrite && (index == `IDX_CUR_START);
	wire         wrCurEnd   = dataWrite && (index == `IDX_CUR_END);
	wire         wrStartHi  = dataWrite && (index == `IDX_START_HIGH);
	wire         wrStartLo  = dataWrite && (index == `IDX_START_LOW);
	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			index                <= 6'h00;
			horizBlankStart      <= `REG_RESET;
			horizBlankEnd        <= `REG_RESET;
			horizRetraceStart    <= `REG_RESET;
			horizRetraceEnd      <= `REG_RESET;
			verticalTotalLow     <= `REG_RESET;
			verticalOverflowBits <= `REG_RESET;
			rowScanPreset        <= `REG_RESET;
			maxScanLine          <= `REG_RESET;
			cursorStartLine      <= `REG_RESET;
			cursorEndLine        <= `REG_RESET;
			screenStartHigh      <= `REG_RESET;
			screenStartLow       <= `REG_RESET;
		end else begin
			if (indexWrite) index <= wdata[5:0];
			if (wrHbStart) horizBlankStart <= wdata;
			if (wrHbEnd) horizBlankEnd <= wdata & `HBLANK_END_MASK;
			if (wrHrStart) horizRetraceStart <= wdata;
			if (wrHrEnd) horizRetraceEnd <= wdata;
			if (wrVtotal) verticalTotalLow <= wdata;
			if (wrOvf) verticalOverflowBits <= mergeBits(verticalOverflowBits, wdata, ovfAllow);
			if (wrPreset) rowScanPreset <= wdata & `PRESET_MASK;
			if (wrMaxScan) maxScanLine <= mergeBits(maxScanLine, wdata, maxAllow);
			if (wrCurStart) cursorStartLine <= wdata & `CUR_START_MASK;
			if (wrCurEnd) cursorEndLine <= wdata & `CUR_END_MASK;
			if (wrStartHi) screenStartHigh <= wdata;
			if (wrStartLo) screenStartLow <= wdata;
		end
	end
	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// legacy mode hides the top two high-byte bits
	wire [7:0] startHighView = legacyMode ? (screenStartHigh & `LEGACY_HIGH_MASK)
		: screenStartHigh;
	function automatic logic [7:0] readSel(input logic [5:0] idx);
		unique case (idx)
			`IDX_HBLANK_START: readSel = horizBlankStart;
			`IDX_HBLANK_END:   readSel = horizBlankEnd;
			`IDX_HRTR_START:   readSel = horizRetraceStart;
			`IDX_HRTR_END:     readSel = horizRetraceEnd;
			`IDX_VTOTAL:       readSel = verticalTotalLow;
			`IDX_OVERFLOW:     readSel = verticalOverflowBits;
			`IDX_PRESET:       readSel = rowScanPreset;
			`IDX_MAXSCAN:      readSel = maxScanLine;
			`IDX_CUR_START:    readSel = cursorStartLine;
			`IDX_CUR_END:      readSel = cursorEndLine;
			`IDX_START_HIGH:   readSel = startHighView;
			`IDX_START_LOW:    readSel = screenStartLow;
			default:           readSel = `REG_RESET;
		endcase
	endfunction : readSel
	wire [7:0] readMux = (ioReq.portSel == `PORT_INDEX) ? {2'h0, index} : readSel(index);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ioReadData <= `REG_RESET;
		end else if (ioReq.read) begin
			ioReadData <= readMux;
		end
	end

	// ----------------------------------------------------------------
	// Horizontal character counter and compares
	// ----------------------------------------------------------------
	logic [8:0] hCount;
	logic       blankRaw;
	logic       retraceRaw;
	logic       vRetracePrev;
	logic       halfPhase;
	logic [2:0] deLine;
	logic [2:0] hrLine;
	logic [2:0] curLine;
	// wrap after the last character of the line
	wire        lineEnd      = hCount == ({1'b0, horizTotal} + `HTOTAL_ADJ);
	wire        blankStartHit = hCount == {1'b0, horizBlankStart};
	wire [5:0]  blankEndVal  = {horizRetraceEnd[`HBLANK_END_B5], horizBlankEnd[`LOW5_MSB:0]};
	wire        blankEndHit  = hCount[`LOW6_MSB:0] == blankEndVal;
	wire        rtrStartHit  = hCount == {1'b0, horizRetraceStart};
	wire        rtrEndHit    = hCount[`LOW5_MSB:0] == horizRetraceEnd[`LOW5_MSB:0];
	wire        deRaw        = hCount <= {1'b0, horizDisplayEnd};
	wire [1:0]  deSkew       = horizBlankEnd[`SKEW_MSB:`SKEW_LSB];
	wire [1:0]  rtrDelay     = horizRetraceEnd[`SKEW_MSB:`SKEW_LSB];
	wire [1:0]  curSkew      = cursorEndLine[`SKEW_MSB:`SKEW_LSB];
	// Start wins over end on the same character so a zero-width pulse cannot vanish
	wire        next_blankRaw   = blankStartHit ? 1'b1 : (blankEndHit ? 1'b0 : blankRaw);
	wire        next_retraceRaw = rtrStartHit ? 1'b1 : (rtrEndHit ? 1'b0 : retraceRaw);

	// ----------------------------------------------------------------
	// Row scan counter
	// ----------------------------------------------------------------
	wire        rowTick     = retraceRaw && !next_retraceRaw;
	wire        lineDouble  = maxScanLine[`MAXSCAN_DOUBLE];
	wire        rowStep     = rowTick && (!lineDouble || halfPhase);
	wire        presetLoad  = vRetracePrev && !vRetrace;
	wire [4:0]  maxRow      = maxScanLine[`LOW5_MSB:0];
	wire [4:0]  rowAfter    = (rowScan == maxRow) ? 5'h00 : rowScan + 5'h01;
	// preset after vertical retrace, else step
	wire [4:0]  next_rowScan = presetLoad ? rowScanPreset[`LOW5_MSB:0]
		: (rowStep ? rowAfter : rowScan);

	// ----------------------------------------------------------------
	// Cursor window
	// ----------------------------------------------------------------
	wire [4:0]  curFirst   = cursorStartLine[`LOW5_MSB:0];
	wire [4:0]  curLast    = cursorEndLine[`LOW5_MSB:0];
	// off bit clear, inclusive window, empty when inverted
	wire        curRowHit  = !cursorStartLine[`CURSOR_OFF_BIT] && (curFirst <= curLast)
		&& (rowScan >= curFirst) && (rowScan <= curLast);
	wire        curRaw     = cursorAddrHit && curRowHit;

	// ----------------------------------------------------------------
	// Derived vertical and address values
	// ----------------------------------------------------------------
	// eleven-bit total; legacy row count
	wire [10:0] next_vertTotal = legacyMode
		? {4'h0, verticalTotalLow[`LEGACY_VT_MSB:0]}
		: {vertTotalBit10, verticalOverflowBits[`OVF_VT9], verticalOverflowBits[`OVF_VT8],
			verticalTotalLow};
	// extension bits apply only outside legacy mode
	wire [1:0]  addrExt  = legacyMode ? 2'h0
		: extLockControlReg[`LOCK_ADDR_MSB:`LOCK_ADDR_LSB];
	// panning only matters in multiple-shift modes
	wire [1:0]  next_bytePan = multiShiftMode ? rowScanPreset[`SKEW_MSB:`SKEW_LSB] : 2'h0;
	crtc_timing_pkg::vert_high_t next_vertHigh;
	// overflow fields, start blank and line compare bit 9 from max scan line
	assign next_vertHigh.retraceStart = {verticalOverflowBits[`OVF_VR9],
		verticalOverflowBits[`OVF_VR8]};
	assign next_vertHigh.dispEnd      = {verticalOverflowBits[`OVF_DE9],
		verticalOverflowBits[`OVF_DE8]};
	assign next_vertHigh.startBlank   = {maxScanLine[`MAXSCAN_VB9],
		verticalOverflowBits[`OVF_VB8]};
	assign next_vertHigh.lineCompare  = {maxScanLine[`MAXSCAN_LC9],
		verticalOverflowBits[`OVF_LC8]};

	// ----------------------------------------------------------------
	// Timing state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hCount       <= 9'h000;
			blankRaw     <= 1'b0;
			retraceRaw   <= 1'b0;
			vRetracePrev <= 1'b0;
			halfPhase    <= 1'b0;
			rowScan      <= 5'h00;
			deLine       <= 3'h0;
			hrLine       <= 3'h0;
			curLine      <= 3'h0;
		end else begin
			hCount       <= lineEnd ? 9'h000 : hCount + 9'h001;
			blankRaw     <= next_blankRaw;
			retraceRaw   <= next_retraceRaw;
			vRetracePrev <= vRetrace;
			halfPhase    <= presetLoad ? 1'b0 : (rowTick ? !halfPhase : halfPhase);
			rowScan      <= next_rowScan;
			deLine       <= {deLine[1:0], deRaw};
			hrLine       <= {hrLine[1:0], retraceRaw};
			curLine      <= {curLine[1:0], curRaw};
		end
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hRetrace      <= 1'b0;
			hBlank        <= 1'b0;
			displayEnable <= 1'b0;
			cursorVideo   <= 1'b0;
			bytePan       <= 2'h0;
			vertTotal     <= 11'h000;
			vertHigh      <= '0;
			startAddress  <= 18'h00000;
		end else begin
			hRetrace      <= pickDelayed(retraceRaw, hrLine, rtrDelay);
			hBlank        <= blankRaw;
			displayEnable <= pickDelayed(deRaw, deLine, deSkew);
			cursorVideo   <= pickDelayed(curRaw, curLine, curSkew);
			bytePan       <= next_bytePan;
			vertTotal     <= next_vertTotal;
			vertHigh      <= next_vertHigh;
			startAddress  <= {addrExt, startHighView, screenStartLow};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_retrace_nodelay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rtrDelay == 2'h0 && $past(rtrDelay) == 2'h0) |-> hRetrace == $past(retraceRaw))
		else $error("Retrace with zero delay does not follow raw retrace");
	chk_retrace_delay3: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rtrDelay == 2'h3 && $past(rtrDelay) == 2'h3 && $past(retraceRaw, 4) && $past(rst_n, 4))
		|-> hRetrace)
		else $error("Retrace with delay three came out late or early");
	chk_blank_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(blankEndHit && !blankStartHit) |=> !blankRaw)
		else $error("Blanking did not end on the six-bit match");
	chk_retrace_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rtrStartHit |=> retraceRaw)
		else $error("Retrace did not start at the programmed count");
	chk_hlock_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(dataWrite && index == `IDX_HRTR_END && horizLock) |=> $stable(horizRetraceEnd))
		else $error("End retrace register changed while locked");
	chk_vtotal_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(dataWrite && index == `IDX_VTOTAL && vertLock) |=> $stable(verticalTotalLow))
		else $error("Vertical total changed while locked");
	chk_ovf_line_cmp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wrOvf |=> verticalOverflowBits[`OVF_LC8] == $past(wdata[`OVF_LC8]))
		else $error("Line compare bit 8 was not written");
	chk_ovf_de_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrOvf && deLock) |=> verticalOverflowBits[`OVF_DE9] == $past(verticalOverflowBits[`OVF_DE9]))
		else $error("Display end bit 9 changed while locked");
	chk_row_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rowStep && !presetLoad && rowScan == maxRow) |=> rowScan == 5'h00)
		else $error("Row scan did not clear at the maximum");
	chk_cursor_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cursorStartLine[`CURSOR_OFF_BIT] [*5] |-> !cursorVideo)
		else $error("Cursor shown while disabled");
	chk_blank_bit7: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ioReq.read && ioReq.portSel == `PORT_DATA && index == `IDX_HBLANK_END) |=> !ioReadData[7])
		else $error("End blank bit 7 read back as one");
	chk_hcount_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lineEnd |=> hCount == 9'h000)
		else $error("Character counter did not wrap at line end");

endmodule : crtc_timing_cursor_regs

`default_nettype wire

// [verif/display_sink.sv]
// Display-side model that times the horizontal retrace pulses it receives
`timescale 1ns/1ps
`default_nettype none
module display_sink (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       hRetrace,
	output logic [7:0]      linePeriod
);
	logic [7:0] cnt;
	logic       prev;
	// ----------------------------------------------------------------
	// Line length between retrace rises
	// ----------------------------------------------------------------
	// retrace period
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			prev <= 1'b0;
			linePeriod <= 8'h00;
		end else begin
			prev <= hRetrace;
			cnt <= (hRetrace && !prev) ? 8'h00 : cnt + 8'h01;
			if (hRetrace && !prev) linePeriod <= cnt + 8'h01;
		end
	end
endmodule : display_sink
`default_nettype wire

// [verif/crtc_timing_cursor_regs_tb_top.sv]
// Self-checking bench for the timing and cursor register block
`timescale 1ns/1ps
`default_nettype none
module crtc_timing_cursor_regs_tb_top;
	logic                        ref_clk = 1'b0, rst_n = 1'b0, rdSeen = 1'b0;
	logic                        wp = 1'b0, legacy = 1'b0, vtB10 = 1'b0, ms = 1'b1;
	logic [7:0]                  ext = 8'h00, rnd, linePeriod, ioReadData, vh;
	crtc_timing_pkg::io_req_t    ioReq = '0;
	crtc_timing_pkg::vert_high_t vertHigh;
	logic                        hRetrace, hBlank, displayEnable, cursorVideo;
	logic [4:0]                  rowScan;
	logic [1:0]                  bytePan;
	logic [10:0]                 vertTotal;
	logic [17:0]                 startAddress, expQ[$];
	int                          bad_count = 0, check_count = 0, cycles = 0, n;
	always #2 ref_clk = ~ref_clk;
	crtc_timing_cursor_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .ioReq(ioReq),
		.extLockControlReg(ext), .timingWriteProtect(wp), .legacyMode(legacy),
		.multiShiftMode(ms), .horizTotal(8'h0b), .horizDisplayEnd(8'h07),
		.vertTotalBit10(vtB10), .vRetrace(1'b0), .cursorAddrHit(1'b1),
		.ioReadData(ioReadData), .hRetrace(hRetrace), .hBlank(hBlank),
		.displayEnable(displayEnable), .cursorVideo(cursorVideo), .rowScan(rowScan),
		.bytePan(bytePan), .vertTotal(vertTotal), .vertHigh(vertHigh),
		.startAddress(startAddress));
	display_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .hRetrace(hRetrace),
		.linePeriod(linePeriod));
	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------
	task cmp(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task cyc(input logic w, input logic r, input logic p, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		ioReq = '{w, r, p, d};
	endtask : cyc
	task wr(input logic [7:0] idx, input logic [7:0] val);
		cyc(1'b1, 1'b0, 1'b0, idx);
		cyc(1'b1, 1'b0, 1'b1, val);
		cyc(1'b0, 1'b0, 1'b0, 8'h00);
	endtask : wr
	task tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tick
	// Edges from a rise of blank (or retrace) until blank (or display enable) falls
	task span(input logic pick, output int cnt);
		if (pick) @(posedge hBlank);
		else @(posedge hRetrace);
		#1;
		cnt = 0;
		while (pick ? hBlank : displayEnable) begin
			@(posedge ref_clk);
			#1;
			cnt++;
		end
	endtask : span
	// Read result is noted now and compared by the watcher three edges later
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		cyc(1'b1, 1'b0, 1'b0, idx);
		expQ.push_back({10'h000, exp});
		cyc(1'b0, 1'b1, 1'b1, 8'h00);
		cyc(1'b0, 1'b0, 1'b0, 8'h00);
	endtask : rd
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	// ----------------------------------------------------------------
	// Watcher and timeout
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rdSeen) cmp({10'h000, ioReadData}, expQ.pop_front());
		rdSeen <= ioReq.read;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h8b1f));
		rnd = 8'($urandom);
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		wr(8'h02, 8'h0a);
		wr(8'h03, 8'hee);
		rd(8'h03, 8'h6e);
		cmp({17'h00000, cursorVideo}, 18'h00001);
		wr(8'h0a, 8'h20);
		tick(2);
		cmp({17'h00000, cursorVideo}, 18'h00000);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h7f);
		cmp({16'h0000, bytePan}, 18'h00003);
		ms = 1'b0;
		tick(2);
		cmp({16'h0000, bytePan}, 18'h00000);
		wr(8'h04, 8'h02);
		wr(8'h05, 8'h04);
		ext = 8'h20;
		wr(8'h05, 8'h55);
		rd(8'h05, 8'h04);
		tick(40);
		cmp({10'h000, linePeriod}, 18'h00010);
		span(1'b1, n);
		cmp(18'(n), 18'h00004);
		span(1'b0, n);
		cmp(18'(n), 18'h00008);
		ext = 8'h00;
		wp = 1'b1;
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h10);
		ext = 8'h02;
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h52);
		ext = 8'h01;
		wp = 1'b0;
		wr(8'h09, 8'hff);
		rd(8'h09, 8'hdf);
		vh = vertHigh;
		cmp({10'h000, vh}, 18'h00033);
		ext = 8'h00;
		vtB10 = 1'b1;
		wr(8'h06, 8'ha5);
		wr(8'h07, 8'hff);
		wp = 1'b1;
		wr(8'h06, 8'h00);
		rd(8'h06, 8'ha5);
		cmp({7'h00, vertTotal}, 18'h007a5);
		wp = 1'b0;
		ext = 8'h18;
		wr(8'h0c, 8'hff);
		wr(8'h0d, rnd);
		tick(1);
		cmp(startAddress, {2'b11, 8'hff, rnd});
		legacy = 1'b1;
		tick(2);
		cmp(startAddress, {2'b00, 8'h3f, rnd});
		cmp({7'h00, vertTotal}, 18'h00025);
		print_verdict();
	end
endmodule : crtc_timing_cursor_regs_tb_top
`default_nettype wire
